/* vamc_pkg.sv */
/*
 * Package for the valve actuator motor control block: timing constants,
 * drive states and the packed carriers shared by the design files.
 * Assumes a single 40 MHz system clock and an active-low async reset.
 */
// Overview of operation
// - Open drives open terminal high, close terminal low; close reverses polarity.
// - With outputs off both terminals go to negative supply for braking.
// - Limit inputs conduct in travel; open input means limit tripped.
// - Open limit open: open drive disabled, red indicator flashes.
// - Close limit open: close drive disabled, green indicator flashes.
// - From both off, a command waits its own delay before driving.
// - A command withdrawn before its delay ends never drives.
// - Local mode: open button drives open, close button drives close.
// - Button presses pass through the same open and close delays.
// - Local mode ignores wire mode and behaves as three-wire.
// - One output turns on only after the other is off.
// - Both commands together turn both outputs off; in two-wire mode the close command is ignored and the open command drives open.
// - Remote mode ignores buttons and uses external commands only.
// - Wire mode selector off is three-wire, on is two-wire.
// - Three-wire: each input drives its own output; none means hold.
// - Two-wire: close drives until open command appears, then open.
// - Normally red shows open drive, green shows close drive.
// - Blink 0.4 s on and 0.4 s off; flash 10 cycles per second.
// - Supply below 10V disables motor and blinks both indicators.
// - After low supply recovers, stay off and blink three more seconds.
// - Supply above 30V over one second: motor off, both lit.
// - Overcurrent stops motor until opposite direction is commanded.
// - A current trip lights yellow indicator and switches trip relay.
// - Open and close delays each settable from 0.02 to 12 seconds.
// - A current trip also clears on external reset low.
package vamc_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // Times in milliseconds
    localparam int unsigned BLINK_HALF_MS = 400;
    localparam int unsigned FLASH_HALF_MS = 50;
    localparam int unsigned LOW_HOLD_MS = 3000;
    localparam int unsigned OVER_QUAL_MS = 1000;
    localparam int unsigned DELAY_MIN_MS = 20;
    localparam int unsigned DELAY_MAX_MS = 12000;
    localparam int unsigned DEBOUNCE_MS = 5;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;
    localparam int unsigned LOW_HOLD_CYC = LOW_HOLD_MS * CYC_PER_MS;
    localparam int unsigned OVER_QUAL_CYC = OVER_QUAL_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned DELAY_SET_W = 8;
    // Drive states of the motor bridge
    typedef enum logic [1:0] {VAMC_IDLE, VAMC_WAIT_OPEN, VAMC_WAIT_CLOSE, VAMC_RUN} vamc_state_t;
    // Cleaned operator inputs
    typedef struct packed {
        logic open_cmd;
        logic close_cmd;
        logic open_btn;
        logic close_btn;
        logic open_limit_ok;
        logic close_limit_ok;
    } vamc_inputs_t;
    // Indicator set
    typedef struct packed {
        logic red;
        logic green;
        logic yellow;
    } vamc_leds_t;
endpackage

/* vamc_debounce.sv */
/*
 * Two-flop synchroniser followed by a stability counter for one input.
 * Assumes the input is a slow mechanical or isolated level.
 */
`timescale 1ns/10ps
module vamc_debounce #(
    parameter int unsigned STABLE_CYC = 200000,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic raw_in,
    output logic clean_out
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    logic sync1;
    logic sync2;
    logic [CW-1:0] cnt;

    // Synchroniser, first flop feeds only the second
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1 <= RESET_VAL;
            sync2 <= RESET_VAL;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end

    // Accept a new level only after it has been stable long enough
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= '0;
            clean_out <= RESET_VAL;
        end else if (sync2 == clean_out) begin
            cnt <= '0;
        end else if (cnt == CW'(STABLE_CYC - 1)) begin
            cnt <= '0;
            clean_out <= sync2;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule

/* vamc_timer.sv */
/*
 * Down-counting one-shot timer: load starts, done is high once expired.
 * Assumes load and the count are presented in the same cycle.
 */
`timescale 1ns/10ps
module vamc_timer #(
    parameter int W = 32
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic load_in,
    input wire logic [W-1:0] count_in,
    output logic done_out
);
    logic [W-1:0] remain;

    // Count down to zero after each load
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            remain <= '0;
        end else if (load_in) begin
            remain <= count_in;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign done_out = (remain == '0) && !load_in;
endmodule

/* vamc_top.sv */
/*
 * Valve actuator motor control: command selection, input delays,
 * interlock, limit handling, supply and current fault handling, indicators.
 * Assumes comparator levels for supply and current are already digital
 * and synchronous, and the drive stage follows the terminal outputs.
 */
`timescale 1ns/10ps
module vamc_top #(
    parameter int unsigned DEBOUNCE_CYC = vamc_pkg::DEBOUNCE_CYC,
    parameter int unsigned BLINK_HALF_CYC = vamc_pkg::BLINK_HALF_CYC,
    parameter int unsigned FLASH_HALF_CYC = vamc_pkg::FLASH_HALF_CYC,
    parameter int unsigned LOW_HOLD_CYC = vamc_pkg::LOW_HOLD_CYC,
    parameter int unsigned OVER_QUAL_CYC = vamc_pkg::OVER_QUAL_CYC,
    parameter int unsigned DELAY_MIN_CYC = vamc_pkg::DELAY_MIN_MS * vamc_pkg::CYC_PER_MS,
    parameter int unsigned DELAY_MAX_CYC = vamc_pkg::DELAY_MAX_MS * vamc_pkg::CYC_PER_MS
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic open_cmd_in,
    input wire logic close_cmd_in,
    input wire logic open_btn_in,
    input wire logic close_btn_in,
    input wire logic open_limit_in,
    input wire logic close_limit_in,
    input wire logic local_remote_selector_in,
    input wire logic wire_mode_selector_in,
    input wire logic [vamc_pkg::DELAY_SET_W-1:0] open_delay_setting_in,
    input wire logic [vamc_pkg::DELAY_SET_W-1:0] close_delay_setting_in,
    input wire logic supply_low_in,
    input wire logic supply_high_in,
    input wire logic overcurrent_in,
    input wire logic trip_reset_n_in,
    output logic motor_open_hi_out,
    output logic motor_open_lo_out,
    output logic motor_close_hi_out,
    output logic motor_close_lo_out,
    output logic led_red_out,
    output logic led_green_out,
    output logic led_yellow_out,
    output logic trip_relay_out
);
    localparam int TW = 32;
    localparam int unsigned DSPAN = DELAY_MAX_CYC - DELAY_MIN_CYC;
    localparam int unsigned DSTEPS = (1 << vamc_pkg::DELAY_SET_W) - 1;

    vamc_pkg::vamc_inputs_t raw;
    vamc_pkg::vamc_inputs_t cln;
    vamc_pkg::vamc_state_t state;
    vamc_pkg::vamc_leds_t leds;
    logic want_open;
    logic want_close;
    logic dly_load;
    logic [TW-1:0] dly_count;
    logic dly_done;
    logic run_open;
    logic trip;
    logic trip_dir_open;
    logic low_hold;
    logic [TW-1:0] low_cnt;
    logic [TW-1:0] over_cnt;
    logic over_flag;
    logic [TW-1:0] blink_cnt;
    logic blink;
    logic [TW-1:0] flash_cnt;
    logic flash;
    logic supply_fault;
    logic drive_open;
    logic drive_close;

    // Map a pot setting onto the delay range
    function automatic logic [TW-1:0] delay_cycles(input logic [vamc_pkg::DELAY_SET_W-1:0] s);
        logic [63:0] prod;
        prod = 64'(DSPAN) * 64'(s) / 64'(DSTEPS);
        return TW'(DELAY_MIN_CYC + prod[31:0]);
    endfunction

    assign raw = '{open_cmd: open_cmd_in, close_cmd: close_cmd_in,
                   open_btn: open_btn_in, close_btn: close_btn_in,
                   open_limit_ok: open_limit_in, close_limit_ok: close_limit_in};

    // Clean every command, button and limit input
    for (genvar i = 0; i < $bits(vamc_pkg::vamc_inputs_t); i++) begin : g_deb
        vamc_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b0)) u_deb (
            .clk_sys_in(clk_sys_in),
            .nrst_in(nrst_in),
            .raw_in(raw[i]),
            .clean_out(cln[i])
        );
    end

    // Command selection by mode
    always_comb begin
        if (local_remote_selector_in) begin
            want_open = cln.open_btn; // Local: buttons only, three-wire
            want_close = cln.close_btn;
        end else if (wire_mode_selector_in) begin
            want_open = cln.open_cmd; // Two-wire: close unless open
            want_close = !cln.open_cmd;
        end else begin
            want_open = cln.open_cmd; // Remote three-wire
            want_close = cln.close_cmd;
        end
        // Both together means neither
        if (want_open && want_close) begin
            want_open = 1'b0;
            want_close = 1'b0;
        end
    end

    vamc_timer #(.W(TW)) u_dly (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .load_in(dly_load),
        .count_in(dly_count),
        .done_out(dly_done)
    );

    // Inhibit terms: limits open supply faults trip
    assign drive_open = want_open && cln.open_limit_ok && !supply_fault
                        && !(trip && trip_dir_open);
    assign drive_close = want_close && cln.close_limit_ok && !supply_fault
                         && !(trip && !trip_dir_open);

    // Delay start when idle and a drive request appears
    assign dly_load = (state == vamc_pkg::VAMC_IDLE) && (drive_open || drive_close);
    assign dly_count = drive_open ? delay_cycles(open_delay_setting_in)
                                  : delay_cycles(close_delay_setting_in);

    // Drive sequencing; RUN always passes through IDLE before reversing
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= vamc_pkg::VAMC_IDLE;
            run_open <= 1'b0;
        end else begin
            unique case (state)
                vamc_pkg::VAMC_IDLE: begin
                    if (drive_open) begin
                        state <= vamc_pkg::VAMC_WAIT_OPEN;
                    end else if (drive_close) begin
                        state <= vamc_pkg::VAMC_WAIT_CLOSE;
                    end
                end
                vamc_pkg::VAMC_WAIT_OPEN: begin
                    if (!drive_open) begin
                        state <= vamc_pkg::VAMC_IDLE; // Withdrawn early
                    end else if (dly_done) begin
                        state <= vamc_pkg::VAMC_RUN;
                        run_open <= 1'b1;
                    end
                end
                vamc_pkg::VAMC_WAIT_CLOSE: begin
                    if (!drive_close) begin
                        state <= vamc_pkg::VAMC_IDLE;
                    end else if (dly_done) begin
                        state <= vamc_pkg::VAMC_RUN;
                        run_open <= 1'b0;
                    end
                end
                vamc_pkg::VAMC_RUN: begin
                    if (run_open ? !drive_open : !drive_close) begin
                        state <= vamc_pkg::VAMC_IDLE;
                    end
                end
            endcase
        end
    end

    // Current trip latch; set wins over clear
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            trip <= 1'b0;
            trip_dir_open <= 1'b0;
        end else if (overcurrent_in && state == vamc_pkg::VAMC_RUN) begin
            trip <= 1'b1;
            trip_dir_open <= run_open;
        end else if (!trip_reset_n_in) begin
            trip <= 1'b0;
        end else if (trip && (trip_dir_open ? want_close : want_open)) begin
            trip <= 1'b0; // Opposite command clears
        end
    end

    // Low supply and three-second recovery hold
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_hold <= 1'b0;
            low_cnt <= '0;
        end else if (supply_low_in) begin
            low_hold <= 1'b1;
            low_cnt <= '0;
        end else if (low_hold) begin
            if (low_cnt == TW'(LOW_HOLD_CYC - 1)) begin
                low_hold <= 1'b0;
                low_cnt <= '0;
            end else begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end

    // Overvoltage qualified for more than one second
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            over_cnt <= '0;
            over_flag <= 1'b0;
        end else if (!supply_high_in) begin
            over_cnt <= '0;
            over_flag <= 1'b0;
        end else if (over_cnt == TW'(OVER_QUAL_CYC)) begin
            over_flag <= 1'b1;
        end else begin
            over_cnt <= over_cnt + 1'b1;
        end
    end

    assign supply_fault = low_hold || over_flag || supply_low_in;

    // Blink and flash pattern generators
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            blink_cnt <= '0;
            blink <= 1'b0;
        end else if (blink_cnt == TW'(BLINK_HALF_CYC - 1)) begin
            blink_cnt <= '0;
            blink <= !blink;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flash_cnt <= '0;
            flash <= 1'b0;
        end else if (flash_cnt == TW'(FLASH_HALF_CYC - 1)) begin
            flash_cnt <= '0;
            flash <= !flash;
        end else begin
            flash_cnt <= flash_cnt + 1'b1;
        end
    end

    // Indicator priority: supply faults, then limits, then motor
    always_comb begin
        leds.yellow = trip;
        if (over_flag) begin
            leds.red = 1'b1;
            leds.green = 1'b1;
        end else if (low_hold || supply_low_in) begin
            leds.red = blink;
            leds.green = blink;
        end else begin
            leds.red = cln.open_limit_ok ? (state == vamc_pkg::VAMC_RUN && run_open) : flash;
            leds.green = cln.close_limit_ok ? (state == vamc_pkg::VAMC_RUN && !run_open) : flash;
        end
    end

    // Registered terminal drive: polarity by direction, braking when off
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            motor_open_hi_out <= 1'b0;
            motor_open_lo_out <= 1'b1;
            motor_close_hi_out <= 1'b0;
            motor_close_lo_out <= 1'b1;
        end else begin
            motor_open_hi_out <= (state == vamc_pkg::VAMC_RUN) && run_open;
            motor_open_lo_out <= !((state == vamc_pkg::VAMC_RUN) && run_open);
            motor_close_hi_out <= (state == vamc_pkg::VAMC_RUN) && !run_open;
            motor_close_lo_out <= !((state == vamc_pkg::VAMC_RUN) && !run_open);
        end
    end

    // Registered indicators and relay
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            led_red_out <= 1'b0;
            led_green_out <= 1'b0;
            led_yellow_out <= 1'b0;
            trip_relay_out <= 1'b0;
        end else begin
            led_red_out <= leds.red;
            led_green_out <= leds.green;
            led_yellow_out <= leds.yellow;
            trip_relay_out <= trip;
        end
    end

    // Never both high sides together
    AST_NO_SHOOT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !(motor_open_hi_out && motor_close_hi_out)) else $error("both drives on");
    // Idle means both terminals low side
    AST_BRAKE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (state != vamc_pkg::VAMC_RUN) |=> (motor_open_lo_out && motor_close_lo_out))
        else $error("brake missing");
    AST_OPEN_POL: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        motor_open_hi_out |-> !motor_open_lo_out && motor_close_lo_out)
        else $error("open polarity wrong");
    AST_SUPPLY_STOP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        supply_fault |=> ##1 !motor_open_hi_out && !motor_close_hi_out)
        else $error("supply fault drove motor");
    AST_LIMIT_OPEN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !cln.open_limit_ok |=> ##1 !motor_open_hi_out) else $error("open past limit");
    AST_LIMIT_CLOSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !cln.close_limit_ok |=> ##1 !motor_close_hi_out) else $error("close past limit");
    AST_WITHDRAW: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (state == vamc_pkg::VAMC_WAIT_OPEN && !drive_open) |=> state == vamc_pkg::VAMC_IDLE)
        else $error("withdrawn command ran");
    AST_OVER_LEDS: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        over_flag |=> led_red_out && led_green_out) else $error("overvoltage leds");
    AST_TRIP_RELAY: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $rose(trip) |=> trip_relay_out && led_yellow_out) else $error("trip outputs");
    AST_BOTH_CMD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (cln.open_cmd && cln.close_cmd && !local_remote_selector_in && !wire_mode_selector_in)
        |-> !want_open && !want_close) else $error("both commands passed");
endmodule

/* vamc_motor_model.sv */
/*
 * Behavioural DC actuator with open and close end-of-travel switches.
 * Assumes the four bridge terminal outputs of the control block drive it.
 */
`timescale 1ns/10ps
module vamc_motor_model #(
    parameter int TRAVEL = 400
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic open_hi_in,
    input wire logic open_lo_in,
    input wire logic close_hi_in,
    input wire logic close_lo_in,
    output logic open_limit_out,
    output logic close_limit_out,
    output logic short_out
);
    int pos;
    // Shaft moves only with one terminal high and the other low
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pos <= TRAVEL / 2;
        end else if (open_hi_in && close_lo_in && !close_hi_in && pos < TRAVEL) begin
            pos <= pos + 1;
        end else if (close_hi_in && open_lo_in && !open_hi_in && pos > 0) begin
            pos <= pos - 1;
        end
    end
    // Switches conduct in travel and open at the ends
    assign open_limit_out = (pos < TRAVEL);
    assign close_limit_out = (pos > 0);
    // High and low side together on one terminal shorts the supply
    assign short_out = (open_hi_in && open_lo_in) || (close_hi_in && close_lo_in);
endmodule

/* vamc_top_tb.sv */
/*
 * Self-checking bench for the valve actuator motor control block.
 * Assumes the actuator model closes the limit loop; 40 MHz clock.
 */
`timescale 1ns/10ps
module vamc_top_tb;
    localparam logic [3:0] OPN = 4'h9;
    localparam logic [3:0] CLS = 4'h6;
    localparam logic [3:0] BRK = 4'h5;
    logic clk, nrst, ocmd, ccmd, obtn, cbtn, slo, shi, oc, trip_rst_n;
    logic local_remote_selector, wire_mode_selector;
    logic [7:0] open_delay_setting, close_delay_setting;
    logic olim, clim, ohi, olo, chi, clo, red, grn, yel, rly, shrt;
    int failures = 0;
    int cmp_count = 0;
    wire logic [3:0] drv = {ohi, olo, chi, clo};
    wire logic [3:0] leds = {red, grn, yel, rly};
    // Shortened timing so a full run fits in a few thousand cycles
    localparam int unsigned T_DEB = 4;
    localparam int unsigned T_BLINK = 8;
    localparam int unsigned T_FLASH = 2;
    localparam int unsigned T_LOW = 20;
    localparam int unsigned T_OVER = 10;
    localparam int unsigned T_DMIN = 3;
    localparam int unsigned T_DMAX = 258;

    vamc_top #(.DEBOUNCE_CYC(T_DEB), .BLINK_HALF_CYC(T_BLINK), .FLASH_HALF_CYC(T_FLASH),
        .LOW_HOLD_CYC(T_LOW), .OVER_QUAL_CYC(T_OVER), .DELAY_MIN_CYC(T_DMIN),
        .DELAY_MAX_CYC(T_DMAX)) u_dut (
        .clk_sys_in(clk), .nrst_in(nrst), .open_cmd_in(ocmd), .close_cmd_in(ccmd),
        .open_btn_in(obtn), .close_btn_in(cbtn), .open_limit_in(olim), .close_limit_in(clim),
        .local_remote_selector_in(local_remote_selector),
        .wire_mode_selector_in(wire_mode_selector),
        .open_delay_setting_in(open_delay_setting), .close_delay_setting_in(close_delay_setting),
        .supply_low_in(slo), .supply_high_in(shi), .overcurrent_in(oc),
        .trip_reset_n_in(trip_rst_n), .motor_open_hi_out(ohi), .motor_open_lo_out(olo),
        .motor_close_hi_out(chi), .motor_close_lo_out(clo), .led_red_out(red),
        .led_green_out(grn), .led_yellow_out(yel), .trip_relay_out(rly));

    vamc_motor_model u_motor (.clk_sys_in(clk), .nrst_in(nrst),
        .open_hi_in(ohi), .open_lo_in(olo), .close_hi_in(chi), .close_lo_in(clo),
        .open_limit_out(olim), .close_limit_out(clim), .short_out(shrt));

    // Clock source
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_drive(input logic [3:0] exp, input int lim);
        int n;
        n = 0;
        while (drv !== exp && n < lim) begin
            @(negedge clk);
            n++;
        end
        check("drive", drv, exp);
    endtask

    task automatic hold_drive(input logic [3:0] exp, input int n);
        logic [3:0] seen;
        seen = exp;
        repeat (n) begin
            @(negedge clk);
            if (drv !== exp) seen = drv;
        end
        check("drive_hold", seen, exp);
    endtask

    task automatic toggles(input int n, output int r, output int g);
        logic pr, pg;
        r = 0;
        g = 0;
        pr = red;
        pg = grn;
        repeat (n) begin
            @(negedge clk);
            r += int'(red !== pr);
            g += int'(grn !== pg);
            pr = red;
            pg = grn;
        end
    endtask

    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Bridge terminals must never conflict
    always @(negedge clk) begin
        if (nrst === 1'b1 && ((ohi & chi) | shrt) !== 1'b0) begin
            failures++;
            $display("unexpected bridge_conflict expected 0 seen 1");
        end
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end

    // Main sequence
    initial begin
        int r, g;
        {nrst, ocmd, ccmd, obtn, cbtn, slo, shi, oc} = '0;
        {local_remote_selector, wire_mode_selector} = 2'h0;
        trip_rst_n = 1'b1;
        open_delay_setting = 8'hFF;
        close_delay_setting = 8'h64;
        repeat (10) @(negedge clk);
        check("reset_drive", drv, BRK);
        check("reset_leds", leds, 4'h0);
        nrst = 1'b1;
        repeat (20) @(negedge clk);
        // Slowest open delay, then run into the open end of travel
        ocmd = 1'b1;
        hold_drive(BRK, 260);
        wait_drive(OPN, 300);
        check("open_leds", leds, 4'h8);
        wait_drive(BRK, 600);
        toggles(40, r, g);
        check("open_flash", 4'(r >= 15 && g == 0), 4'h1);
        ocmd = 1'b0;
        // Close command withdrawn before its delay ends
        ccmd = 1'b1;
        repeat (60) @(negedge clk);
        ccmd = 1'b0;
        hold_drive(BRK, 150);
        // Buttons ignored in remote, delayed in local
        close_delay_setting = 8'h20;
        cbtn = 1'b1;
        hold_drive(BRK, 80);
        local_remote_selector = 1'b1;
        hold_drive(BRK, 25);
        wait_drive(CLS, 60);
        // Let the open limit settle through its debounce before reading leds
        repeat (10) @(negedge clk);
        check("close_leds", leds, 4'h4);
        cbtn = 1'b0;
        repeat (20) @(negedge clk);
        open_delay_setting = 8'h00;
        obtn = 1'b1;
        wait_drive(OPN, 60);
        obtn = 1'b0;
        wait_drive(BRK, 20);
        wire_mode_selector = 1'b1;
        hold_drive(BRK, 60);
        // Two-wire remote with the close input left idle
        local_remote_selector = 1'b0;
        wait_drive(CLS, 80);
        ocmd = 1'b1;
        wait_drive(OPN, 60);
        wire_mode_selector = 1'b0;
        repeat (10) @(negedge clk);
        ocmd = 1'b0;
        wait_drive(BRK, 20);
        // Three-wire close, both commands, supply faults
        close_delay_setting = 8'h00;
        ccmd = 1'b1;
        wait_drive(CLS, 40);
        ocmd = 1'b1;
        wait_drive(BRK, 20);
        hold_drive(BRK, 20);
        ocmd = 1'b0;
        wait_drive(CLS, 40);
        slo = 1'b1;
        wait_drive(BRK, 10);
        toggles(40, r, g);
        check("low_blink", 4'(r >= 4 && r <= 5 && r == g && red === grn), 4'h1);
        slo = 1'b0;
        hold_drive(BRK, 25);
        wait_drive(CLS, 40);
        shi = 1'b1;
        hold_drive(CLS, 12);
        wait_drive(BRK, 10);
        check("over_leds", leds, 4'hC);
        shi = 1'b0;
        wait_drive(CLS, 40);
        // Current trip, cleared by trip reset and by reversal
        oc = 1'b1;
        wait_drive(BRK, 10);
        oc = 1'b0;
        check("trip_leds", leds, 4'h3);
        hold_drive(BRK, 30);
        trip_rst_n = 1'b0;
        repeat (10) @(negedge clk);
        trip_rst_n = 1'b1;
        wait_drive(CLS, 40);
        check("cleared_leds", leds, 4'h4);
        oc = 1'b1;
        wait_drive(BRK, 10);
        oc = 1'b0;
        ccmd = 1'b0;
        ocmd = 1'b1;
        wait_drive(OPN, 40);
        check("reversed_leds", leds, 4'h8);
        // Run to the close end of travel
        ocmd = 1'b0;
        ccmd = 1'b1;
        wait_drive(CLS, 60);
        wait_drive(BRK, 1000);
        toggles(40, r, g);
        check("close_flash", 4'(g >= 15 && r == 0), 4'h1);
        results();
    end
endmodule
